// file: src/iopc_pkg.sv
// iopc_pkg: shared constants of the per-pin io controller
// assumes a 32-bit classic wishbone slave and eight pins
package iopc_pkg;
    localparam int          PINS       = 8;
    localparam int          FUNCS      = 8;
    localparam int          ALT_FUNCS  = 7;
    localparam int          FSEL_W     = 3;
    localparam int          DS_W       = 3;
    localparam int          MODE_W     = 2;

    // register word offsets (byte address bits 7:2)
    localparam logic [5:0]  OFS_MODE   = 6'h00;
    localparam logic [5:0]  OFS_PULL   = 6'h01;
    localparam logic [5:0]  OFS_DRIVE  = 6'h02;
    localparam logic [5:0]  OFS_FUNC   = 6'h03;
    localparam logic [5:0]  OFS_DEB    = 6'h04;
    localparam logic [5:0]  OFS_DOUT   = 6'h05;
    localparam logic [5:0]  OFS_DIN    = 6'h06;
    localparam logic [5:0]  OFS_ITYPE  = 6'h07;
    localparam logic [5:0]  OFS_IEN    = 6'h08;
    localparam logic [5:0]  OFS_IFLAG  = 6'h09;

    // field positions inside PULL and ITYPE
    localparam int          PU_LSB     = 0;
    localparam int          PD_LSB     = 8;
    localparam int          LVL_LSB    = 0;
    localparam int          RISE_LSB   = 8;
    localparam int          FALL_LSB   = 16;

    // values after reset
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE   = 8'h00;

    // pins that may be routed to a converter channel
    localparam logic [7:0]  ANALOG_CAPABLE = 8'hF0;

    // debounce: stable samples needed before a new level passes
    localparam logic [3:0]  DEB_SAMPLES = 4'h8;

    typedef enum logic [1:0] {
        IOPC_MODE_INPUT,
        IOPC_MODE_PUSH_PULL,
        IOPC_MODE_OPEN_DRAIN,
        IOPC_MODE_ANALOG
    } iopc_mode_t;
endpackage

// file: src/iopc_debounce.sv
// iopc_debounce: per-pin noise filter on an already synchronised level
// assumes the input is in the mclk_in domain
`timescale 1ns/100ps
module iopc_debounce (
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    input  wire logic enable_in,
    input  wire logic level_in,
    output logic      level_out
);
    logic [3:0] count;
    wire        differs  = level_in != level_out;
    wire        settled  = count == iopc_pkg::DEB_SAMPLES - 4'h1;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count     <= 4'h0;
            level_out <= 1'b0;
        end else if (!enable_in) begin
            count     <= 4'h0;
            level_out <= level_in;
        end else if (!differs) begin
            count     <= 4'h0;
        end else if (settled) begin
            count     <= 4'h0;
            level_out <= level_in;
        end else begin
            count     <= count + 4'h1;
        end
    end
endmodule

// file: src/iopc_top.sv
// iopc_top: eight-pin io controller with function selector and pin interrupts
// assumes a classic wishbone master, pads outside resolve pad_out/pad_oe
`timescale 1ns/100ps

// Notes on behaviour
// - each pin is push-pull output, open-drain output or high-impedance input
// - each pin has its own weak pull-up and pull-down enable
// - each pin has a debounce filter, enabled per pin
// - each pin interrupts on level or on edge, chosen per pin
// - edge mode detects rising, falling or both edges
// - each pin has its own interrupt enable and interrupt flag
// - drive strength is programmable per pin in steps
// - per-pin selector picks one of eight functions, function zero is gpio
// - analog setting bypasses the selector; no digital function drives it, only the pin interrupt still samples it
// - only some pins accept the analog setting
module iopc_top (
    input  wire logic                                        mclk_in,
    input  wire logic                                        rst_n_in,
    input  wire logic                                        wb_cyc_in,
    input  wire logic                                        wb_stb_in,
    input  wire logic                                        wb_we_in,
    input  wire logic [7:0]                                  wb_adr_in,
    input  wire logic [3:0]                                  wb_sel_in,
    input  wire logic [31:0]                                 wb_dat_in,
    output logic      [31:0]                                 wb_dat_out,
    output logic                                             wb_ack_out,
    output logic                                             irq_out,
    input  wire logic [iopc_pkg::PINS-1:0][iopc_pkg::ALT_FUNCS-1:0] alt_out_in,
    input  wire logic [iopc_pkg::PINS-1:0][iopc_pkg::ALT_FUNCS-1:0] alt_oe_in,
    output logic      [iopc_pkg::PINS-1:0][iopc_pkg::ALT_FUNCS-1:0] alt_in_out,
    input  wire logic [iopc_pkg::PINS-1:0]                   pad_in,
    output logic      [iopc_pkg::PINS-1:0]                   pad_out,
    output logic      [iopc_pkg::PINS-1:0]                   pad_oe_out,
    output logic      [iopc_pkg::PINS-1:0]                   pad_pull_up_out,
    output logic      [iopc_pkg::PINS-1:0]                   pad_pull_down_out,
    output logic      [iopc_pkg::PINS-1:0][iopc_pkg::DS_W-1:0] pad_drive_out,
    output logic      [iopc_pkg::PINS-1:0]                   analog_en_out
);
    localparam int P = iopc_pkg::PINS;

    // byte-lane merge used by every writable register
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // software-visible registers
    logic [31:0]  mode_reg;
    logic [31:0]  pull_reg;
    logic [31:0]  drive_reg;
    logic [31:0]  func_reg;
    logic [31:0]  deb_reg;
    logic [31:0]  dout_reg;
    logic [31:0]  itype_reg;
    logic [31:0]  ien_reg;
    logic [P-1:0] iflag;

    // input path
    logic [P-1:0] sync1;
    logic [P-1:0] sync2;
    logic [P-1:0] sync3;
    logic [P-1:0] pin_level;
    logic [P-1:0] filt;
    logic [P-1:0] filt_prev;
    logic [P-1:0] din_view;

    // bus decode
    wire          bus_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire          bus_wr     = bus_req && wb_we_in;
    wire [5:0]    word       = wb_adr_in[7:2];
    wire          wr_mode    = bus_wr && word == iopc_pkg::OFS_MODE;
    wire          wr_pull    = bus_wr && word == iopc_pkg::OFS_PULL;
    wire          wr_drive   = bus_wr && word == iopc_pkg::OFS_DRIVE;
    wire          wr_func    = bus_wr && word == iopc_pkg::OFS_FUNC;
    wire          wr_deb     = bus_wr && word == iopc_pkg::OFS_DEB;
    wire          wr_dout    = bus_wr && word == iopc_pkg::OFS_DOUT;
    wire          wr_itype   = bus_wr && word == iopc_pkg::OFS_ITYPE;
    wire          wr_ien     = bus_wr && word == iopc_pkg::OFS_IEN;
    wire          wr_iflag   = bus_wr && word == iopc_pkg::OFS_IFLAG;
    wire [31:0]   wr_masked  = merge_lanes(32'h0000_0000, wb_dat_in, wb_sel_in);

    logic [31:0]  next_rdata;
    always_comb begin
        case (word)
            iopc_pkg::OFS_MODE:  next_rdata = {16'h0000, mode_reg[15:0]};
            iopc_pkg::OFS_PULL:  next_rdata = {16'h0000, pull_reg[15:0]};
            iopc_pkg::OFS_DRIVE: next_rdata = {8'h00, drive_reg[23:0]};
            iopc_pkg::OFS_FUNC:  next_rdata = {8'h00, func_reg[23:0]};
            iopc_pkg::OFS_DEB:   next_rdata = {24'h000000, deb_reg[7:0]};
            iopc_pkg::OFS_DOUT:  next_rdata = {24'h000000, dout_reg[7:0]};
            iopc_pkg::OFS_DIN:   next_rdata = {24'h000000, din_view};
            iopc_pkg::OFS_ITYPE: next_rdata = {8'h00, itype_reg[23:0]};
            iopc_pkg::OFS_IEN:   next_rdata = {24'h000000, ien_reg[7:0]};
            iopc_pkg::OFS_IFLAG: next_rdata = {24'h000000, iflag};
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    // per-pin decoded settings
    logic [P-1:0] is_analog;
    logic [P-1:0] edge_hit;
    logic [P-1:0] evt;
    logic [P-1:0] next_pad_out;
    logic [P-1:0] next_pad_oe;
    logic [P-1:0] next_pu;
    logic [P-1:0] next_pd;
    logic [P-1:0][iopc_pkg::ALT_FUNCS-1:0] next_alt_in;

    genvar g;
    generate
        for (g = 0; g < P; g++) begin : g_pin
            wire [1:0]                  mode_f = mode_reg[g*2 +: 2];
            wire [iopc_pkg::FSEL_W-1:0] fsel   = func_reg[g*3 +: 3];
            wire                        analog = mode_f == iopc_pkg::IOPC_MODE_ANALOG
                                                 && iopc_pkg::ANALOG_CAPABLE[g];
            wire                        gpio   = fsel == 3'h0;
            wire                        dsel   = gpio ? dout_reg[g] : alt_out_in[g][fsel - 3'h1];
            wire                        oreq   = gpio ? 1'b1 : alt_oe_in[g][fsel - 3'h1];
            wire                        rise   = filt[g] && !filt_prev[g];
            wire                        fall   = !filt[g] && filt_prev[g];

            assign is_analog[g] = analog;
            assign din_view[g]  = analog ? 1'b0 : filt[g];
            assign edge_hit[g]  = (rise && itype_reg[iopc_pkg::RISE_LSB + g])
                                  || (fall && itype_reg[iopc_pkg::FALL_LSB + g]);
            assign evt[g]       = itype_reg[iopc_pkg::LVL_LSB + g] ? filt[g] : edge_hit[g];

            // push-pull drives both levels, open-drain only pulls low
            assign next_pad_out[g] = (mode_f == iopc_pkg::IOPC_MODE_PUSH_PULL) && dsel;
            assign next_pad_oe[g]  = analog ? 1'b0 :
                                     (mode_f == iopc_pkg::IOPC_MODE_PUSH_PULL)  ? oreq :
                                     (mode_f == iopc_pkg::IOPC_MODE_OPEN_DRAIN) ? (oreq && !dsel) :
                                     1'b0;
            assign next_pu[g] = !analog && pull_reg[iopc_pkg::PU_LSB + g];
            assign next_pd[g] = !analog && pull_reg[iopc_pkg::PD_LSB + g];

            for (genvar f = 0; f < iopc_pkg::ALT_FUNCS; f++) begin : g_fn
                // a peripheral sees the pin only while it owns it
                assign next_alt_in[g][f] = !analog && fsel == 3'(f + 1) && filt[g];
            end

            iopc_debounce u_deb (
                .mclk_in   (mclk_in),
                .rst_n_in  (rst_n_in),
                .enable_in (deb_reg[g]),
                .level_in  (pin_level[g]),
                .level_out (filt[g])
            );
        end
    endgenerate

    // three-stage pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1     <= iopc_pkg::RST_BYTE;
            sync2     <= iopc_pkg::RST_BYTE;
            sync3     <= iopc_pkg::RST_BYTE;
            pin_level <= iopc_pkg::RST_BYTE;
            filt_prev <= iopc_pkg::RST_BYTE;
        end else begin
            sync1     <= pad_in;
            sync2     <= sync1;
            sync3     <= sync2;
            pin_level <= (sync2 & sync3) | (pin_level & (sync2 ^ sync3));
            filt_prev <= filt;
        end
    end

    // register writes
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg  <= iopc_pkg::RST_WORD;
            pull_reg  <= iopc_pkg::RST_WORD;
            drive_reg <= iopc_pkg::RST_WORD;
            func_reg  <= iopc_pkg::RST_WORD;
            deb_reg   <= iopc_pkg::RST_WORD;
            dout_reg  <= iopc_pkg::RST_WORD;
            itype_reg <= iopc_pkg::RST_WORD;
            ien_reg   <= iopc_pkg::RST_WORD;
        end else begin
            if (wr_mode)  mode_reg  <= merge_lanes(mode_reg, wb_dat_in, wb_sel_in);
            if (wr_pull)  pull_reg  <= merge_lanes(pull_reg, wb_dat_in, wb_sel_in);
            if (wr_drive) drive_reg <= merge_lanes(drive_reg, wb_dat_in, wb_sel_in);
            if (wr_func)  func_reg  <= merge_lanes(func_reg, wb_dat_in, wb_sel_in);
            if (wr_deb)   deb_reg   <= merge_lanes(deb_reg, wb_dat_in, wb_sel_in);
            if (wr_dout)  dout_reg  <= merge_lanes(dout_reg, wb_dat_in, wb_sel_in);
            if (wr_itype) itype_reg <= merge_lanes(itype_reg, wb_dat_in, wb_sel_in);
            if (wr_ien)   ien_reg   <= merge_lanes(ien_reg, wb_dat_in, wb_sel_in);
        end
    end

    // sticky flags: an event in the clearing cycle keeps the flag set
    wire [P-1:0] flag_clr   = wr_iflag ? wr_masked[P-1:0] : iopc_pkg::RST_BYTE;
    wire [P-1:0] next_iflag = (iflag & ~flag_clr) | evt;

    // bus answer and registered pad side
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            iflag             <= iopc_pkg::RST_BYTE;
            wb_ack_out        <= 1'b0;
            wb_dat_out        <= iopc_pkg::RST_WORD;
            irq_out           <= 1'b0;
            pad_out           <= iopc_pkg::RST_BYTE;
            pad_oe_out        <= iopc_pkg::RST_BYTE;
            pad_pull_up_out   <= iopc_pkg::RST_BYTE;
            pad_pull_down_out <= iopc_pkg::RST_BYTE;
            pad_drive_out     <= '0;
            analog_en_out     <= iopc_pkg::RST_BYTE;
            alt_in_out        <= '0;
        end else begin
            iflag             <= next_iflag;
            wb_ack_out        <= bus_req;
            wb_dat_out        <= bus_req ? next_rdata : iopc_pkg::RST_WORD;
            irq_out           <= |(next_iflag & ien_reg[P-1:0]);
            pad_out           <= next_pad_out;
            pad_oe_out        <= next_pad_oe;
            pad_pull_up_out   <= next_pu;
            pad_pull_down_out <= next_pd;
            pad_drive_out     <= drive_reg[P*iopc_pkg::DS_W-1:0];
            analog_en_out     <= is_analog;
            alt_in_out        <= next_alt_in;
        end
    end
endmodule

// file: test/iopc_assertions.sv
// iopc_assertions: port-level checks of the io controller
// assumes binding into iopc_top, one clock domain
`timescale 1ns/100ps
module iopc_assertions (
    input  wire logic            mclk_in,
    input  wire logic            rst_n_in,
    input  wire logic            wb_cyc_in,
    input  wire logic            wb_stb_in,
    input  wire logic            wb_ack_out,
    input  wire logic [31:0]     wb_dat_out,
    input  wire logic [7:0]      pad_oe_out,
    input  wire logic [7:0]      pad_pull_up_out,
    input  wire logic [7:0]      pad_pull_down_out,
    input  wire logic [7:0]      analog_en_out,
    input  wire logic [7:0][6:0] alt_in_out
);
    logic [7:0] an_sampled;
    logic [7:0] multi_fn;
    for (genvar p = 0; p < 8; p++) begin : g_pin
        assign an_sampled[p] = analog_en_out[p] & (|alt_in_out[p]);
        assign multi_fn[p]   = !$onehot0(alt_in_out[p]);
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    chk_ack_answers: assert property (s_req |=> wb_ack_out) else $error("no ack after request");
    chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
    chk_ack_caused: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in)) else $error("ack without request");
    chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data outside ack");
    chk_analog_capable: assert property ((analog_en_out & ~iopc_pkg::ANALOG_CAPABLE) == 8'h00)
        else $error("analog on incapable pin");
    chk_analog_undriven: assert property ((analog_en_out & (pad_oe_out | pad_pull_up_out | pad_pull_down_out)) == 8'h00)
        else $error("analog pin driven or pulled");
    chk_analog_unsampled: assert property (an_sampled == 8'h00) else $error("analog pin sampled");
    chk_fn_single: assert property (multi_fn == 8'h00) else $error("pin level fed to two functions");
endmodule

// file: test/iopc_pad_model.sv
// iopc_pad_model: external circuitry on the eight pads
// assumes the bench never drives a pad the controller drives
`timescale 1ns/100ps
module iopc_pad_model (
    input  wire logic       mclk_in,
    input  wire logic [7:0] pad_out_in,
    input  wire logic [7:0] pad_oe_in,
    input  wire logic [7:0] pull_up_in,
    input  wire logic [7:0] pull_down_in,
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    output logic      [7:0] pad_level_out
);
    logic [7:0] float_q = 8'h00;
    // undriven unpulled pads wander every cycle
    always_ff @(posedge mclk_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            pad_level_out[p] = pad_oe_in[p] ? pad_out_in[p] : ext_en_in[p] ? ext_val_in[p] :
                (pull_up_in[p] | pull_down_in[p]) ? pull_up_in[p] : float_q[p];
        end
    end
endmodule

// file: test/tb.sv
// tb: register-level regression of the io controller
// assumes the pad model resolves every pin level
`timescale 1ns/100ps
module tb;
    logic            mclk_in = 1'b0;
    logic            rst_n_in = 1'b0;
    logic            wb_cyc = 1'b0;
    logic            wb_stb = 1'b0;
    logic            wb_we = 1'b0;
    logic [7:0]      wb_adr = 8'h00;
    logic [3:0]      wb_sel = 4'hF;
    logic [3:0]      lanes = 4'hF;
    logic [31:0]     wb_wdat = 32'h0;
    logic [31:0]     wb_dat_out;
    logic            wb_ack_out;
    logic            irq_out;
    logic [7:0][6:0] alt_out = 56'h0;
    logic [7:0][6:0] alt_oe = 56'h0;
    logic [7:0][6:0] alt_in_out;
    logic [7:0]      pad_in;
    logic [7:0]      pad_out;
    logic [7:0]      pad_oe_out;
    logic [7:0]      pull_up;
    logic [7:0]      pull_down;
    logic [7:0]      analog_en_out;
    logic [7:0][2:0] pad_drive_out;
    logic [7:0]      ext_en = 8'hFF;
    logic [7:0]      ext_val = 8'h00;
    logic [31:0]     q;
    int              miscompares = 0;
    int              tests_run = 0;
    int              cycles = 0;

    initial begin
        forever #2 mclk_in = ~mclk_in;
    end

    iopc_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .irq_out(irq_out), .alt_out_in(alt_out),
        .alt_oe_in(alt_oe), .alt_in_out(alt_in_out), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_out(pad_oe_out), .pad_pull_up_out(pull_up), .pad_pull_down_out(pull_down),
        .pad_drive_out(pad_drive_out), .analog_en_out(analog_en_out));

    iopc_pad_model u_pads (.mclk_in(mclk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe_out),
        .pull_up_in(pull_up), .pull_down_in(pull_down), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .pad_level_out(pad_in));

    task automatic summarize();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= lanes;
        wb_wdat <= d;
        // ends on ack; if ack never comes, only the bench timeout ends this wait
        do begin
            @(posedge mclk_in);
        end while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), q, e);
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rchk(8'(i * 4), 32'h0);
        end
        wb(1'b1, 8'h04, 32'h0000_1002);
        wb(1'b1, 8'h00, 32'h0000_0339);
        ext_en <= 8'hFC;
        rchk(8'h00, 32'h0000_0339);
        check("analog", analog_en_out, 8'h10);
        check("pull up", pull_up, 8'h02);
        check("pull down", pull_down, 8'h00);
        wb(1'b1, 8'h00, 32'h0000_0009);
        wb(1'b1, 8'h14, 32'h0000_0003);
        repeat (6) @(posedge mclk_in);
        check("oe", pad_oe_out, 8'h01);
        check("pads", pad_in & 8'h03, 8'h03);
        check("pull down", pull_down, 8'h10);
        wb(1'b1, 8'h14, 32'h0);
        repeat (3) @(posedge mclk_in);
        check("oe", pad_oe_out, 8'h03);
        check("out", pad_out, 8'h00);
        wb(1'b1, 8'h08, 32'hFFFA_C688);
        rchk(8'h08, 32'h00FA_C688);
        check("drive", pad_drive_out, 24'hFAC688);
        lanes = 4'h2;
        wb(1'b1, 8'h08, 32'h5555_1155);
        lanes = 4'hF;
        rchk(8'h08, 32'h00FA_1188);
        alt_out <= 56'hFF_FFFF_FFFF_FFFF;
        alt_oe <= 56'hFF_FFFF_FFFF_FFFF;
        for (int f = 0; f < 8; f++) begin
            wb(1'b1, 8'h0C, 32'(f));
            repeat (8) @(posedge mclk_in);
            check("func out", pad_out[0], 64'(f != 0));
            check("func in", alt_in_out, (f == 0) ? 56'h0 : 56'h1 << (f - 1));
        end
        wb(1'b1, 8'h0C, 32'h0);
        wb(1'b1, 8'h10, 32'h0000_0004);
        ext_val <= 8'h0C;
        repeat (4) @(posedge mclk_in);
        rchk(8'h18, 32'h0000_0008);
        rchk(8'h18, 32'h0000_0008);
        rchk(8'h18, 32'h0000_0008);
        rchk(8'h18, 32'h0000_000C);
        repeat (20) @(posedge mclk_in);
        wb(1'b1, 8'h18, 32'h0000_00FF);
        rchk(8'h18, 32'h0000_000C);
        rchk(8'h3C, 32'h0);
        wb(1'b1, 8'h1C, 32'h00C0_A010);
        wb(1'b1, 8'h20, 32'h0000_0030);
        wb(1'b1, 8'h24, 32'h0000_00FF);
        ext_val <= 8'hFC;
        repeat (10) @(posedge mclk_in);
        rchk(8'h24, 32'h0000_00B0);
        check("irq", irq_out, 1'b1);
        ext_val <= 8'h0C;
        repeat (10) @(posedge mclk_in);
        rchk(8'h24, 32'h0000_00F0);
        wb(1'b1, 8'h24, 32'h0000_0030);
        rchk(8'h24, 32'h0000_00C0);
        check("irq", irq_out, 1'b0);
        ext_val <= 8'h1C;
        repeat (10) @(posedge mclk_in);
        wb(1'b1, 8'h24, 32'h0000_00FF);
        rchk(8'h24, 32'h0000_0010);
        check("irq", irq_out, 1'b1);
        wb(1'b1, 8'h00, 32'h0000_0309);
        wb(1'b1, 8'h0C, 32'h0000_1000);
        repeat (4) @(posedge mclk_in);
        check("analog in", alt_in_out, 56'h0);
        rchk(8'h18, 32'h0000_000C);
        summarize();
    end
endmodule

bind iopc_top iopc_assertions u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out), .pad_oe_out(pad_oe_out),
    .pad_pull_up_out(pad_pull_up_out), .pad_pull_down_out(pad_pull_down_out),
    .analog_en_out(analog_en_out), .alt_in_out(alt_in_out));
